// ---- pkg/epm_pkg.sv ----
package epm_pkg;
  // register word offsets (bytes); aliases sit above each base
  localparam logic [7:0] SUPP_BASE     = 8'h00;
  localparam logic [7:0] MCFG_BASE     = 8'h10;
  localparam logic [7:0] MADR_BASE     = 8'h20;
  localparam logic [7:0] STAT_BASE     = 8'h30;
  localparam logic [3:0] ALIAS_WR      = 4'h0;
  localparam logic [3:0] ALIAS_CLR     = 4'h4;
  localparam logic [3:0] ALIAS_SET     = 4'h8;
  localparam logic [3:0] ALIAS_INV     = 4'hc;
  // field positions
  localparam int SUPP_RST_BIT  = 11;
  localparam int SUPP_SPD_BIT  = 8;
  localparam int MCFG_RST_BIT  = 15;
  localparam int MCFG_SEL_LO   = 2;
  localparam int MCFG_SKIP_PREAMBLE    = 1;
  localparam int MCFG_SCAN     = 0;
  // writable masks and values after reset
  localparam logic [31:0] SUPP_MASK  = 32'h0000_0900;
  localparam logic [31:0] MCFG_MASK  = 32'h0000_803f;
  localparam logic [31:0] MADR_MASK  = 32'h0000_1f1f;
  localparam logic [31:0] SUPP_RESET = 32'h0000_0000;
  localparam logic [31:0] MCFG_RESET = 32'h0000_0020;
  localparam logic [31:0] MADR_RESET = 32'h0000_0100;
  // preamble length in mdc cycles
  localparam logic [5:0]  PREAMBLE_LEN = 6'h20;
  // header and released phase lengths in mdc cycles
  localparam logic [5:0]  HEAD_LEN     = 6'h0e;
  localparam logic [5:0]  TURN_LEN     = 6'h12;
  // divider encodings to half period counts
  function automatic logic [4:0] epm_half_div(input logic [3:0] sel);
    case (sel)
      4'h0, 4'h1: epm_half_div = 5'h02;
      4'h2:       epm_half_div = 5'h03;
      4'h3:       epm_half_div = 5'h04;
      4'h4:       epm_half_div = 5'h05;
      4'h5:       epm_half_div = 5'h07;
      4'h6:       epm_half_div = 5'h0a;
      4'h7:       epm_half_div = 5'h0e;
      default:    epm_half_div = 5'h14;
    endcase
  endfunction : epm_half_div
endpackage : epm_pkg

// ---- src/epm_mdc_div.sv ----
`timescale 1ns/10ps
module epm_mdc_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hold,
  input  wire logic [3:0] sel,
  output logic            mdc_q,
  output logic            rise_q
);
  logic [4:0] cnt_q;
  logic [4:0] half;
  assign half = epm_pkg::epm_half_div(sel);
  // divide core clock; hold keeps the divider at its start state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 5'h00;
      mdc_q  <= 1'b0;
      rise_q <= 1'b0;
    end else if (hold) begin
      cnt_q  <= 5'h00;
      mdc_q  <= 1'b0;
      rise_q <= 1'b0;
    end else if (cnt_q + 5'h01 >= half) begin
      cnt_q  <= 5'h00;
      mdc_q  <= ~mdc_q;
      rise_q <= ~mdc_q;
    end else begin
      cnt_q  <= cnt_q + 5'h01;
      rise_q <= 1'b0;
    end
  end
endmodule : epm_mdc_div

// ---- src/epm_top.sv ----
// What this block does
// - phy support bit 11 holds the reduced interface logic in reset.
// - phy support bit 8 selects 100 Mbps when one, 10 Mbps when zero.
// - those two bits act only on the reduced interface logic.
// - 16 and 32 bit accesses work, aliases too; byte accesses ignored.
// - unimplemented bits, 31 to 16 among them, read as zero.
// - config bit 15 resets the management block, all but SCAN_PHY_ADDR (which holds its value), while set.
// - mdc is divided from the core clock by config bits 5 to 2.
// - divider codes 0 to 7 give 4,4,6,8,10,14,20,28; codes 8 and up all give 40.
// - config bit 1 drops the 32 bit preamble from cycles.
// - config bit 0 scans phy addresses 1 up to the programmed address.
// - each writable register has clear, set, invert aliases at 0x4, 0x8, 0xc.
`timescale 1ns/10ps
module epm_top (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             RMII_RESET,
  output logic             RMII_SPEED_100,
  output logic             MDC,
  output logic             MDIO_O,
  output logic             MDIO_OE,
  output logic      [4:0]  SCAN_PHY_ADDR
);
  logic [31:0] supp_q;
  logic [31:0] mcfg_q;
  logic [31:0] madr_q;
  logic        req;
  logic        sel_ok;
  logic [7:0]  base;
  logic [3:0]  alias_off;
  logic [31:0] wmask;
  logic        mgmt_rst;
  logic        mdc_int;
  logic        mdc_prev_q;
  logic        mdc_fall;
  logic [31:0] rd_d;

  // a new request only when ack is low, keeping classic single cycles
  assign req       = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign base      = {WB_ADR_I[7:4], 4'h0};
  assign alias_off = WB_ADR_I[3:0];
  // byte access (one lane only, or odd lane pairs) is refused silently
  assign sel_ok    = (WB_SEL_I == 4'hf) || (WB_SEL_I == 4'h3) || (WB_SEL_I == 4'hc);
  assign wmask     = {{16{WB_SEL_I[3]}}, {16{WB_SEL_I[1]}}};

  function automatic logic [31:0] alias_apply(input logic [31:0] cur, input logic [31:0] wd,
                                               input logic [3:0] off, input logic [31:0] lanes,
                                               input logic [31:0] impl);
    logic [31:0] m;
    logic [31:0] nv;
    m = lanes & impl;
    case (off)
      epm_pkg::ALIAS_WR:  nv = (cur & ~m) | (wd & m);
      epm_pkg::ALIAS_CLR: nv = cur & ~(wd & m);
      epm_pkg::ALIAS_SET: nv = cur | (wd & m);
      epm_pkg::ALIAS_INV: nv = cur ^ (wd & m);
      default:            nv = cur;
    endcase
    alias_apply = nv;
  endfunction : alias_apply

  // write strobes; a refused lane pattern never reaches a register
  logic wr_en;
  logic wr_supp;
  logic wr_mcfg;
  logic wr_madr;
  assign wr_en   = req && WB_WE_I && sel_ok;
  assign wr_supp = wr_en && (base == epm_pkg::SUPP_BASE);
  assign wr_mcfg = wr_en && (base == epm_pkg::MCFG_BASE);
  assign wr_madr = wr_en && (base == epm_pkg::MADR_BASE);

  // phy support register; only bits 11 and 8 ever store
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      supp_q <= epm_pkg::SUPP_RESET;
    end else if (wr_supp) begin
      supp_q <= alias_apply(supp_q, WB_DAT_I, alias_off, wmask, epm_pkg::SUPP_MASK);
    end
  end

  // management config register
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mcfg_q <= epm_pkg::MCFG_RESET;
    end else if (wr_mcfg) begin
      mcfg_q <= alias_apply(mcfg_q, WB_DAT_I, alias_off, wmask, epm_pkg::MCFG_MASK);
    end
  end

  // management address register: phy address and register address
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      madr_q <= epm_pkg::MADR_RESET;
    end else if (wr_madr) begin
      madr_q <= alias_apply(madr_q, WB_DAT_I, alias_off, wmask, epm_pkg::MADR_MASK);
    end
  end

  // read mux; unmapped reads zero, unimplemented bits zero
  always_comb begin
    case (base)
      epm_pkg::SUPP_BASE: rd_d = supp_q & epm_pkg::SUPP_MASK;
      epm_pkg::MCFG_BASE: rd_d = mcfg_q & epm_pkg::MCFG_MASK;
      epm_pkg::MADR_BASE: rd_d = madr_q & epm_pkg::MADR_MASK;
      epm_pkg::STAT_BASE: rd_d = {26'h0, MDIO_OE, SCAN_PHY_ADDR};
      default:            rd_d = 32'h0000_0000;
    endcase
  end

  // one wait state answer; every request acked, even refused ones
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= req;
    end
  end

  // read data stands only with ack; refused reads return zero
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_DAT_O <= (req && !WB_WE_I && sel_ok) ? rd_d : 32'h0000_0000;
    end
  end

  // reduced interface reset, unused by other phy interfaces
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RMII_RESET <= 1'b0;
    end else begin
      RMII_RESET <= supp_q[epm_pkg::SUPP_RST_BIT];
    end
  end

  // reduced interface line rate select
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RMII_SPEED_100 <= 1'b0;
    end else begin
      RMII_SPEED_100 <= supp_q[epm_pkg::SUPP_SPD_BIT];
    end
  end

  assign mgmt_rst = mcfg_q[epm_pkg::MCFG_RST_BIT];

  // mdc divider; software picks a code keeping mdc slow enough
  epm_mdc_div u_div (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .hold   (mgmt_rst),
    .sel    (mcfg_q[epm_pkg::MCFG_SEL_LO +: 4]),
    .mdc_q  (mdc_int),
    .rise_q ()
  );

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MDC <= 1'b0;
    end else begin
      MDC <= mdc_int & ~mgmt_rst;
    end
  end

  // falling point of the divided clock; mdio moves here so that it has
  // settled half a period before the phy samples on the rising edge
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_int;
    end
  end
  assign mdc_fall = mdc_prev_q & ~mdc_int;

  // scan read engine: preamble, then 14 frame bits driven, 18 released
  typedef enum {ST_IDLE, ST_PRE, ST_HEAD, ST_TURN} epm_state_t;
  epm_state_t  st_q;
  logic [5:0]  bit_q;
  logic [13:0] hdr_q;
  logic [4:0]  phy_q;
  logic [4:0]  phy_max;
  logic [4:0]  phy_now;
  logic        scan_on;
  assign phy_max = madr_q[12:8];
  assign scan_on = mcfg_q[epm_pkg::MCFG_SCAN];
  assign phy_now = scan_on ? phy_q : phy_max;

  // true on the last count of a phase that is len bits long
  function automatic logic at_last(input logic [5:0] cnt, input logic [5:0] len);
    at_last = (cnt == len - 6'h01);
  endfunction : at_last

  // start 01, read 10, phy address, register address
  function automatic logic [13:0] frame_head(input logic [4:0] phy, input logic [4:0] regad);
    frame_head = {4'h6, phy, regad};
  endfunction : frame_head

  // scan order 1..top; a lowered top sends the scan back to 1
  function automatic logic [4:0] next_phy(input logic [4:0] cur, input logic [4:0] top);
    next_phy = (cur < top) ? cur + 5'h01 : 5'h01;
  endfunction : next_phy

  // frame sequencing; every step is taken at the falling point of mdc
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q  <= ST_IDLE;
      bit_q <= 6'h00;
      hdr_q <= 14'h0000;
      phy_q <= 5'h01;
    end else if (mgmt_rst) begin
      st_q  <= ST_IDLE;
      bit_q <= 6'h00;
      hdr_q <= 14'h0000;
      phy_q <= 5'h01;
    end else if (mdc_fall) begin
      case (st_q)
        ST_IDLE: begin
          hdr_q <= frame_head(phy_now, madr_q[4:0]);
          if (mcfg_q[epm_pkg::MCFG_SKIP_PREAMBLE]) begin
            st_q  <= ST_HEAD;
            bit_q <= 6'h00;
          end else begin
            // this step already drives the first preamble one
            st_q  <= ST_PRE;
            bit_q <= 6'h01;
          end
        end
        ST_PRE: begin
          if (at_last(bit_q, epm_pkg::PREAMBLE_LEN)) begin
            st_q  <= ST_HEAD;
            bit_q <= 6'h00;
          end else begin
            bit_q <= bit_q + 6'h01;
          end
        end
        ST_HEAD: begin
          // header leaves msb first
          hdr_q <= {hdr_q[12:0], 1'b0};
          if (at_last(bit_q, epm_pkg::HEAD_LEN)) begin
            st_q  <= ST_TURN;
            bit_q <= 6'h00;
          end else begin
            bit_q <= bit_q + 6'h01;
          end
        end
        ST_TURN: begin
          // turnaround and reply bits: the bus is left to the phy
          if (at_last(bit_q, epm_pkg::TURN_LEN)) begin
            st_q  <= ST_IDLE;
            bit_q <= 6'h00;
            phy_q <= scan_on ? next_phy(phy_q, phy_max) : 5'h01;
          end else begin
            bit_q <= bit_q + 6'h01;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // pin drive; ones through the preamble, released outside preamble and header
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MDIO_O  <= 1'b1;
      MDIO_OE <= 1'b0;
    end else if (mgmt_rst) begin
      MDIO_O  <= 1'b1;
      MDIO_OE <= 1'b0;
    end else if (mdc_fall) begin
      case (st_q)
        ST_IDLE: begin
          // with the preamble skipped the bus stays released one more bit
          MDIO_O  <= 1'b1;
          MDIO_OE <= ~mcfg_q[epm_pkg::MCFG_SKIP_PREAMBLE];
        end
        ST_PRE: begin
          MDIO_O  <= 1'b1;
          MDIO_OE <= 1'b1;
        end
        ST_HEAD: begin
          MDIO_O  <= hdr_q[13];
          MDIO_OE <= 1'b1;
        end
        ST_TURN: begin
          MDIO_OE <= 1'b0;
        end
        default: begin
          MDIO_OE <= 1'b0;
        end
      endcase
    end
  end

  // address of the frame now on the wire, also readable as status
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SCAN_PHY_ADDR <= 5'h00;
    end else if (!mgmt_rst && mdc_fall && (st_q == ST_IDLE)) begin
      SCAN_PHY_ADDR <= phy_now;
    end
  end
endmodule : epm_top

// ---- tb/epm_sva.sv ----
`timescale 1ns/10ps
module epm_sva (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        RMII_RESET,
  input wire logic        RMII_SPEED_100,
  input wire logic        MDC
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic [5:0] hi_q;
  // length of the current mdc high phase
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST) hi_q <= 6'h00;
    else hi_q <= MDC ? hi_q + 6'h01 : 6'h00;
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_cause; WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside ack");
  property p_hi; WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_byte; WB_ACK_O && !(WB_SEL_I inside {4'hf, 4'h3, 4'hc}) |-> WB_DAT_O == 32'h0; endproperty
  a_byte: assert property (p_byte) else $error("byte read data");
  // both outputs move only after an acknowledged write
  property p_rst; $changed(RMII_RESET) |-> $past(WB_ACK_O && WB_WE_I) || $past(WB_ACK_O && WB_WE_I, 2); endproperty
  a_rst: assert property (p_rst) else $error("reset out moved");
  property p_spd; $changed(RMII_SPEED_100) |-> $past(WB_ACK_O && WB_WE_I) || $past(WB_ACK_O && WB_WE_I, 2); endproperty
  a_spd: assert property (p_spd) else $error("speed out moved");
  property p_mdc; hi_q <= 6'h14; endproperty
  a_mdc: assert property (p_mdc) else $error("mdc high too long");
  c_rd: cover property (WB_ACK_O && !WB_WE_I);
  c_rst: cover property ($rose(RMII_RESET));
  c_mdc: cover property ($rose(MDC));
endmodule : epm_sva

// ---- tb/epm_phy_model.sv ----
`timescale 1ns/10ps
module epm_phy_model (
  input  wire logic       rst,
  input  wire logic       mdc,
  input  wire logic       mdio,
  input  wire logic       oe,
  output logic      [5:0] pre_len,
  output logic      [4:0] phy,
  output logic            done
);
  logic       in_pre_q;
  logic [5:0] ones_q;
  logic [3:0] hb_q;
  logic [3:0] sh_q;
  // listen only: the block has no mdio input, so replies would go nowhere
  always_ff @(posedge mdc or posedge rst) begin
    if (rst) begin
      in_pre_q <= 1'b1;
      ones_q <= 6'h00;
      hb_q <= 4'h0;
      pre_len <= 6'h00;
      phy <= 5'h00;
      done <= 1'b0;
    end else if (!oe) begin
      done <= (hb_q != 4'h0);
      in_pre_q <= 1'b1;
      ones_q <= 6'h00;
      hb_q <= 4'h0;
    end else if (in_pre_q && mdio) begin
      ones_q <= ones_q + 6'h01;
    end else begin
      if (in_pre_q) pre_len <= ones_q;
      in_pre_q <= 1'b0;
      hb_q <= (hb_q == 4'hf) ? hb_q : hb_q + 4'h1;
      sh_q <= {sh_q[2:0], mdio};
      if (hb_q == 4'h8) phy <= {sh_q, mdio};
    end
  end
endmodule : epm_phy_model

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic        CLOCK = 1'b0, SYS_RST = 1'b1, cyc = 1'b0, we = 1'b0, ack, rrst, rspd, mdc, mo, oe, done;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, d, e, p;
  logic [5:0]  pre, per = 6'h00, cnt = 6'h00, dv [9] = '{6'h04, 6'h04, 6'h06, 6'h08, 6'h0a, 6'h0e, 6'h14, 6'h1c, 6'h28};
  logic [4:0]  scan, phy;
  logic        mdc_d = 1'b0;
  logic [31:0] q [$];
  integer      seed = 32'hf5199d5f, error_cnt = 0, n_compared = 0, cycles = 0;
  localparam logic [7:0] SU = epm_pkg::SUPP_BASE, MC = epm_pkg::MCFG_BASE;
  epm_top epm_top_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .RMII_RESET(rrst), .RMII_SPEED_100(rspd),
    .MDC(mdc), .MDIO_O(mo), .MDIO_OE(oe), .SCAN_PHY_ADDR(scan));
  epm_phy_model epm_phy_model_i (.rst(SYS_RST), .mdc(mdc), .mdio(mo), .oe(oe), .pre_len(pre), .phy(phy), .done(done));
  initial forever #20 CLOCK = ~CLOCK;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // one classic cycle; request held until the edge that samples ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= v;
    @(posedge CLOCK);
    while (ack !== 1'b1) @(posedge CLOCK);
    cyc <= 1'b0;
    @(posedge CLOCK);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] x);
    q.push_back(x);
    bus(1'b0, a, s, 32'h0);
  endtask : rd
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // read results are matched against the oldest note
  always @(posedge CLOCK) if (ack === 1'b1 && we === 1'b0) chk("read", q.pop_front(), rdat);
  // mdc period in core clocks, taken at every rise
  always @(posedge CLOCK) begin
    mdc_d <= mdc;
    cnt <= (mdc && !mdc_d) ? 6'h01 : cnt + 6'h01;
    if (mdc && !mdc_d) per <= cnt;
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    @(posedge CLOCK);
    rd(SU, 4'hf, 32'h0);
    rd(MC, 4'hf, 32'h20);
    rd(8'h44, 4'hf, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      bus(1'b1, SU, 4'hf, d);
      rd(SU, 4'hf, d & 32'h900);
      chk("rmii_reset", {31'h0, d[11]}, {31'h0, rrst});
      chk("rmii_speed", {31'h0, d[8]}, {31'h0, rspd});
    end
    e = d & 32'h900;
    for (int k = 1; k < 4; k++) begin
      d = $random(seed);
      bus(1'b1, SU + 8'(4 * k), 4'hf, d);
      e = (k == 1 ? e & ~d : k == 2 ? e | d : e ^ d) & 32'h900;
      rd(SU, 4'hf, e);
    end
    bus(1'b1, MC, 4'h1, 32'h0000_00ff);
    bus(1'b1, MC, 4'hc, 32'hffff_ffff);
    rd(MC, 4'hf, 32'h20);
    rd(MC, 4'h2, 32'h0);
    $display("test done: registers");
    for (int c = 0; c < 9; c++) begin
      bus(1'b1, MC, 4'h3, {26'h0, c[3:0], 2'b00});
      repeat (130) @(posedge CLOCK);
      chk("mdc_div", {26'h0, dv[c]}, {26'h0, per});
    end
    $display("test done: divider");
    bus(1'b1, epm_pkg::MADR_BASE, 4'h3, 32'h0300);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, MC, 4'h3, 32'h10 | m); // divide by 10 keeps mdc at 2.5 MHz
      repeat (2) @(posedge done);
      chk("preamble", m[1] ? 32'h0 : 32'h20, {26'h0, pre});
      if (m == 0) chk("phy_fixed", 32'h3, {27'h0, phy});
    end
    bus(1'b1, MC, 4'h3, 32'h11);
    repeat (2) @(posedge done);
    for (int f = 0; f < 4; f++) begin
      p = (phy == 5'h03) ? 32'h1 : {27'h0, phy} + 32'h1;
      @(posedge done);
      chk("phy_scan", p, {27'h0, phy});
      chk("scan_addr", {27'h0, phy}, {27'h0, scan});
    end
    bus(1'b1, MC + 8'h8, 4'h3, 32'h8000);
    d = 32'h0;
    repeat (200) begin
      @(posedge CLOCK);
      d = d | {30'h0, mdc, oe};
    end
    chk("mgmt_held", 32'h0, d);
    bus(1'b1, MC + 8'h4, 4'h3, 32'h8000);
    @(posedge done);
    chk("restart_phy", 32'h1, {27'h0, phy});
    chk("restart_pre", 32'h20, {26'h0, pre});
    $display("test done: management link");
    stop_test();
  end
endmodule : testbench
bind epm_top epm_sva epm_sva_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RMII_RESET(RMII_RESET),
  .RMII_SPEED_100(RMII_SPEED_100), .MDC(MDC));
